// ---- common/lpc_pkg.sv ----
/*
 * Package for the low-power calibration scheduler and trim bank: register
 * indices, field positions, reset values, interval counts and states.
 * Assumes APB word addressing: byte address = 4 * register index.
 */
package lpc_pkg;
   // register indices
   localparam logic [7:0] IDX_BG_EN = 8'h62;
   localparam logic [7:0] IDX_TRIG_CFG = 8'h6B;
   localparam logic [7:0] IDX_SOFT_TRIG = 8'h6C;
   localparam logic [7:0] IDX_LP_CTL = 8'h6E;
   localparam logic [7:0] IDX_STATUS = 8'h70;
   localparam logic [7:0] IDX_GAIN = 8'h7A;
   localparam logic [7:0] IDX_REF = 8'h7C;
   localparam logic [7:0] IDX_TERM_A = 8'h7E;
   localparam logic [7:0] IDX_TERM_B = 8'h7F;

   // lowpower_cal_control fields
   localparam int IDLE_MSB = 7;
   localparam int IDLE_LSB = 5;
   localparam int SETTLE_MSB = 4;
   localparam int SETTLE_LSB = 3;
   localparam int PACED_BIT = 1;
   localparam int LPEN_BIT = 0;
   localparam int REF_W = 4;

   // reset values
   localparam logic [7:0] LP_CTL_RST = 8'h88;
   localparam logic BG_EN_RST = 1'b0;
   localparam logic TRIG_SEL_RST = 1'b0;
   localparam logic SOFT_TRIG_RST = 1'b1;

   // interval lengths in converter clock periods
   localparam int CW = 41;
   localparam logic [7:0][CW-1:0] SLEEP_CNT_DEF = {
      41'h100_0000_0080, 41'h020_0000_0080, 41'h004_0000_0080, 41'h000_8000_0080,
      41'h000_1000_0080, 41'h000_0200_0080, 41'h000_0040_0080, 41'h000_0000_0480};
   localparam logic [3:0][CW-1:0] SETTLE_CNT_DEF = {
      41'h000_8000_0080, 41'h000_1000_0080, 41'h000_0200_0080, 41'h000_0000_0480};

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_SLEEP = 4'h2,
      ST_SETTLE = 4'h4,
      ST_CAL = 4'h8
   } lpc_state_e;
endpackage : lpc_pkg

// ---- hdl/lpc_interval_timer.sv ----
/*
 * Down counter that times the sleep and settle intervals.
 * Assumes the loader passes the interval length minus one.
 */
`timescale 1ns/1ps
module lpc_interval_timer #(
   parameter int CW = lpc_pkg::CW
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [CW-1:0] value_i,
   output logic [CW-1:0] cnt_o,
   output logic expired_o
);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (load_i)
         cnt_nxt = value_i; // see RULE17
      else if (cnt_r != '0)
         cnt_nxt = cnt_r - CW'(1);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt_r <= '0;
      else if (ce_i)
         cnt_r <= cnt_nxt;
   end

   assign cnt_o = cnt_r;
   assign expired_o = (cnt_r == '0);

   cnt_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE17
      (ce_i && !load_i && cnt_r != '0) |=> cnt_r == $past(cnt_r) - CW'(1))
      else $error("interval timer did not step down");
endmodule : lpc_interval_timer

// ---- hdl/lpc_top.sv ----
/*
 * Low-power background calibration scheduler with factory trim bank,
 * reached over APB. Assumes clk_i is the converter clock, fuse inputs are
 * valid at reset release, and cal_done_i ends each calibration.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// Behaviour
// RULE1: idle code bits 7:5 picks sleep length, 1,152 periods up; reset code 4.
// RULE2: sleep length applies only when low-power enabled and not trigger paced.
// RULE3: software should keep idle codes at 4 or above.
// RULE4: settle code bits 4:3 picks wake-to-calibration wait; reset code 1.
// RULE5: settle wait follows every wake in both modes while enabled.
// RULE6: software should keep settle code at 1 or above.
// RULE7: paced bit 0 means autonomous sleep timed from the idle code.
// RULE8: paced bit 1 keeps the core asleep while trigger high, wakes when low.
// RULE9: bit 0 enables low-power calibration, reset 0, needs background enable.
// RULE10: software writes reserved bits, bit 2 included, as zero.
// RULE11: gain trim sets gain of all cores; range changes use range setting.
// RULE12: reference trim bits 3:0, fuse value after reset, writable.
// RULE13: channel A termination trim, fuse value after reset, writable.
// RULE14: gain, reference and channel A trims load from fuses at reset.
// RULE15: channel B termination trim, fuse default, writable.
// RULE16: trigger comes from pin or software bit per source select.
// RULE17: one wide counter times intervals, restarted at sleep entry and wake.
module lpc_top #(
   parameter int AW = 12,
   parameter logic [7:0][lpc_pkg::CW-1:0] SLEEP_CNT = lpc_pkg::SLEEP_CNT_DEF,
   parameter logic [3:0][lpc_pkg::CW-1:0] SETTLE_CNT = lpc_pkg::SETTLE_CNT_DEF
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic cal_trigger_pin_i,
   input wire logic cal_done_i,
   input wire logic [7:0] fuse_gain_i,
   input wire logic [lpc_pkg::REF_W-1:0] fuse_ref_i,
   input wire logic [7:0] fuse_term_a_i,
   input wire logic [7:0] fuse_term_b_i,
   output logic core_sleep_o,
   output logic core_settle_o,
   output logic cal_start_o,
   output logic lp_active_o,
   output logic [7:0] core_gain_adjust_o,
   output logic [lpc_pkg::REF_W-1:0] reference_adjust_o,
   output logic [7:0] termination_adjust_a_o,
   output logic [7:0] termination_adjust_b_o
);
   localparam int CW = lpc_pkg::CW;

   // register bus state
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [7:0] idx;
   logic hit;
   logic wr;

   // control registers
   logic [7:0] lp_ctl_r;
   logic [7:0] lp_ctl_nxt;
   logic bg_en_r;
   logic bg_en_nxt;
   logic trig_sel_r;
   logic trig_sel_nxt;
   logic soft_trig_r;
   logic soft_trig_nxt;
   logic fuse_pend_r;
   logic fuse_pend_nxt;

   // scheduler state
   lpc_pkg::lpc_state_e state_r;
   lpc_pkg::lpc_state_e state_nxt;
   logic sleep_r;
   logic settle_r;
   logic start_r;
   logic active_r;
   logic tmr_load;
   logic [CW-1:0] tmr_val;
   logic [CW-1:0] tmr_cnt;
   logic tmr_done;
   logic [CW-1:0] sleep_ld;
   logic [CW-1:0] settle_ld;
   logic [2:0] idle_code;
   logic [1:0] settle_code;
   logic paced;
   logic lowpower_cal_enable;
   logic active;
   logic cal_trig;
   logic [7:0] gain_q;
   logic [lpc_pkg::REF_W-1:0] ref_q;
   logic [7:0] term_a_q;
   logic [7:0] term_b_q;

   // ---------------- register bus ----------------
   assign idx = paddr_i[9:2];
   assign wr = psel_i && penable_i && pwrite_i && pready_r && !pslverr_r;

   always_comb
   begin
      hit = (paddr_i[AW-1:10] == '0);
      case (idx)
         lpc_pkg::IDX_BG_EN,
         lpc_pkg::IDX_TRIG_CFG,
         lpc_pkg::IDX_SOFT_TRIG,
         lpc_pkg::IDX_LP_CTL,
         lpc_pkg::IDX_STATUS,
         lpc_pkg::IDX_GAIN,
         lpc_pkg::IDX_REF,
         lpc_pkg::IDX_TERM_A,
         lpc_pkg::IDX_TERM_B:
            hit = hit;
         default:
            hit = 1'b0;
      endcase
   end

   // answer is prepared in the setup cycle, so access lasts one cycle
   always_comb
   begin
      pready_nxt = psel_i && !penable_i;
      pslverr_nxt = pslverr_r;
      prdata_nxt = prdata_r;
      if (psel_i && !penable_i)
      begin
         pslverr_nxt = !hit;
         prdata_nxt = 32'h0000_0000;
         case (idx)
            lpc_pkg::IDX_BG_EN:
               prdata_nxt[0] = bg_en_r;
            lpc_pkg::IDX_TRIG_CFG:
               prdata_nxt[0] = trig_sel_r;
            lpc_pkg::IDX_SOFT_TRIG:
               prdata_nxt[0] = soft_trig_r;
            lpc_pkg::IDX_LP_CTL:
               prdata_nxt[7:0] = lp_ctl_r;
            lpc_pkg::IDX_STATUS:
               prdata_nxt[5:0] = {!fuse_pend_r, cal_trig, state_r};
            lpc_pkg::IDX_GAIN:
               prdata_nxt[7:0] = gain_q;
            lpc_pkg::IDX_REF:
               prdata_nxt[lpc_pkg::REF_W-1:0] = ref_q;
            lpc_pkg::IDX_TERM_A:
               prdata_nxt[7:0] = term_a_q;
            lpc_pkg::IDX_TERM_B:
               prdata_nxt[7:0] = term_b_q;
            default:
               prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      lp_ctl_nxt = lp_ctl_r;
      bg_en_nxt = bg_en_r;
      trig_sel_nxt = trig_sel_r;
      soft_trig_nxt = soft_trig_r;
      fuse_pend_nxt = 1'b0;
      if (wr)
      begin
         case (idx)
            lpc_pkg::IDX_LP_CTL:
               lp_ctl_nxt = pwdata_i[7:0];
            lpc_pkg::IDX_BG_EN:
               bg_en_nxt = pwdata_i[0];
            lpc_pkg::IDX_TRIG_CFG:
               trig_sel_nxt = pwdata_i[0];
            lpc_pkg::IDX_SOFT_TRIG:
               soft_trig_nxt = pwdata_i[0];
            default:
               lp_ctl_nxt = lp_ctl_r;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         lp_ctl_r <= lpc_pkg::LP_CTL_RST;
         bg_en_r <= lpc_pkg::BG_EN_RST;
         trig_sel_r <= lpc_pkg::TRIG_SEL_RST;
         soft_trig_r <= lpc_pkg::SOFT_TRIG_RST;
         fuse_pend_r <= 1'b1;
      end
      else if (ce_i)
      begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         lp_ctl_r <= lp_ctl_nxt;
         bg_en_r <= bg_en_nxt;
         trig_sel_r <= trig_sel_nxt;
         soft_trig_r <= soft_trig_nxt;
         fuse_pend_r <= fuse_pend_nxt;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;

   // ---------------- trim bank ----------------
   lpc_trim_reg #(.W(8)) u_gain ( // see RULE11
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(fuse_pend_r),
      .fuse_i(fuse_gain_i), .wr_i(wr && idx == lpc_pkg::IDX_GAIN),
      .wdata_i(pwdata_i[7:0]), .q_o(gain_q));

   lpc_trim_reg #(.W(lpc_pkg::REF_W)) u_ref ( // see RULE12
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(fuse_pend_r),
      .fuse_i(fuse_ref_i), .wr_i(wr && idx == lpc_pkg::IDX_REF),
      .wdata_i(pwdata_i[lpc_pkg::REF_W-1:0]), .q_o(ref_q));

   lpc_trim_reg #(.W(8)) u_term_a ( // see RULE13
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(fuse_pend_r),
      .fuse_i(fuse_term_a_i), .wr_i(wr && idx == lpc_pkg::IDX_TERM_A),
      .wdata_i(pwdata_i[7:0]), .q_o(term_a_q));

   lpc_trim_reg #(.W(8)) u_term_b ( // see RULE15
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(fuse_pend_r),
      .fuse_i(fuse_term_b_i), .wr_i(wr && idx == lpc_pkg::IDX_TERM_B),
      .wdata_i(pwdata_i[7:0]), .q_o(term_b_q));

   assign core_gain_adjust_o = gain_q;
   assign reference_adjust_o = ref_q;
   assign termination_adjust_a_o = term_a_q;
   assign termination_adjust_b_o = term_b_q;

   // ---------------- sleep / wake scheduler ----------------
   assign idle_code = lp_ctl_r[lpc_pkg::IDLE_MSB:lpc_pkg::IDLE_LSB];
   assign settle_code = lp_ctl_r[lpc_pkg::SETTLE_MSB:lpc_pkg::SETTLE_LSB];
   assign paced = lp_ctl_r[lpc_pkg::PACED_BIT];
   assign lowpower_cal_enable = lp_ctl_r[lpc_pkg::LPEN_BIT];
   assign active = lowpower_cal_enable && bg_en_r; // see RULE9
   assign cal_trig = trig_sel_r ? cal_trigger_pin_i : soft_trig_r; // see RULE16
   assign sleep_ld = SLEEP_CNT[idle_code] - CW'(1); // see RULE1
   assign settle_ld = SETTLE_CNT[settle_code] - CW'(1); // see RULE4

   always_comb
   begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      tmr_val = sleep_ld;
      case (state_r)
         lpc_pkg::ST_IDLE:
            if (active)
            begin
               state_nxt = lpc_pkg::ST_SLEEP;
               tmr_load = 1'b1; // see RULE17
            end
         lpc_pkg::ST_SLEEP:
            if (paced ? !cal_trig : tmr_done) // see RULE7, see RULE8
            begin
               state_nxt = lpc_pkg::ST_SETTLE;
               tmr_load = 1'b1; // see RULE5
               tmr_val = settle_ld;
            end
         lpc_pkg::ST_SETTLE:
            if (tmr_done)
               state_nxt = lpc_pkg::ST_CAL;
         lpc_pkg::ST_CAL:
            if (cal_done_i)
            begin
               state_nxt = lpc_pkg::ST_SLEEP;
               tmr_load = 1'b1;
            end
         default:
            state_nxt = lpc_pkg::ST_IDLE;
      endcase
      if (!active)
      begin
         state_nxt = lpc_pkg::ST_IDLE; // see RULE2
         tmr_load = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= lpc_pkg::ST_IDLE;
         sleep_r <= 1'b0;
         settle_r <= 1'b0;
         start_r <= 1'b0;
         active_r <= 1'b0;
      end
      else if (ce_i)
      begin
         state_r <= state_nxt;
         sleep_r <= state_nxt == lpc_pkg::ST_SLEEP;
         settle_r <= state_nxt == lpc_pkg::ST_SETTLE;
         start_r <= state_nxt == lpc_pkg::ST_CAL && state_r != lpc_pkg::ST_CAL;
         active_r <= active;
      end
   end

   lpc_interval_timer #(.CW(CW)) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .load_i(tmr_load),
      .value_i(tmr_val),
      .cnt_o(tmr_cnt),
      .expired_o(tmr_done)
   );

   assign core_sleep_o = sleep_r;
   assign core_settle_o = settle_r;
   assign cal_start_o = start_r;
   assign lp_active_o = active_r;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_sleep_entry;
      ce_i && state_r != lpc_pkg::ST_SLEEP && state_nxt == lpc_pkg::ST_SLEEP;
   endsequence
   sequence s_wake;
      ce_i && state_r == lpc_pkg::ST_SLEEP && state_nxt == lpc_pkg::ST_SETTLE;
   endsequence

   sleep_load_a: assert property (s_sleep_entry |=> tmr_cnt == $past(sleep_ld)) // see RULE1
      else $error("sleep interval loaded wrong");
   sleep_gate_a: assert property ((ce_i && !active) |=> !core_sleep_o ##0 !cal_start_o) // see RULE2
      else $error("scheduler ran while disabled");
   settle_load_a: assert property (s_wake |=> tmr_cnt == $past(settle_ld) ##0 core_settle_o) // see RULE4
      else $error("settle interval loaded wrong");
   settle_path_a: assert property ((ce_i && state_r == lpc_pkg::ST_SLEEP && active // see RULE5
      && state_nxt != lpc_pkg::ST_SLEEP) |=> state_r == lpc_pkg::ST_SETTLE)
      else $error("wake skipped settle");
   auto_wake_a: assert property ((ce_i && state_r == lpc_pkg::ST_SLEEP && active && !paced // see RULE7
      && tmr_done) |=> state_r == lpc_pkg::ST_SETTLE)
      else $error("autonomous wake missed");
   trig_hold_a: assert property ((ce_i && state_r == lpc_pkg::ST_SLEEP && active && paced // see RULE8
      && cal_trig) |=> state_r == lpc_pkg::ST_SLEEP && core_sleep_o)
      else $error("core woke while trigger high");
   trig_wake_a: assert property ((ce_i && state_r == lpc_pkg::ST_SLEEP && active && paced // see RULE8
      && !cal_trig) |=> state_r == lpc_pkg::ST_SETTLE)
      else $error("core not woken on low trigger");
   enable_gate_a: assert property ((ce_i && !bg_en_r) |=> state_r == lpc_pkg::ST_IDLE) // see RULE9
      else $error("low-power active without background enable");
   trig_src_a: assert property ((ce_i && trig_sel_r && state_r == lpc_pkg::ST_SLEEP // see RULE16
      && active && paced && cal_trigger_pin_i) |=> state_r != lpc_pkg::ST_SETTLE)
      else $error("pin trigger ignored");
   settle_end_a: assert property ((ce_i && state_r == lpc_pkg::ST_SETTLE && active && tmr_done) // see RULE17
      |=> cal_start_o ##1 !cal_start_o || !ce_i)
      else $error("calibration start not a single pulse");
   apb_ready_a: assert property ((ce_i && psel_i && !penable_i) |=> pready_o)
      else $error("no answer after setup");
endmodule : lpc_top

// ---- hdl/lpc_trim_reg.sv ----
/*
 * One trim register: takes the fuse value on a load pulse, then software
 * writes. Assumes the load pulse comes once, just after reset release.
 */
`timescale 1ns/1ps
module lpc_trim_reg #(
   parameter int W = 8
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [W-1:0] fuse_i,
   input wire logic wr_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb
   begin
      q_nxt = q_r;
      if (load_i)
         q_nxt = fuse_i; // see RULE14
      else if (wr_i)
         q_nxt = wdata_i; // see RULE12
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         q_r <= '0;
      else if (ce_i)
         q_r <= q_nxt;
   end

   assign q_o = q_r;

   fuse_take_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE14
      (ce_i && load_i) |=> q_r == $past(fuse_i))
      else $error("trim did not take fuse value");
   trim_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE13
      (ce_i && wr_i && !load_i) |=> q_r == $past(wdata_i))
      else $error("trim write lost");
endmodule : lpc_trim_reg

// ---- sim/tb_lowpower_bg_cal_and_trims.sv ----
/*
 * Self-checking bench for the low-power calibration scheduler and trim bank.
 * Assumes lpc_top answers APB with one access cycle and that short interval
 * tables may be passed as parameters in place of the converter-clock counts.
 */
`timescale 1ns/1ps
module tb_lowpower_bg_cal_and_trims;
   // shortened sleep and settle tables, index 0 last
   localparam logic [7:0][40:0] SLP = {41'd29, 41'd26, 41'd23, 41'd20, 41'd17, 41'd14, 41'd11, 41'd8};
   localparam logic [3:0][40:0] STL = {41'd19, 41'd16, 41'd13, 41'd10};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic cal_trigger_pin_i = 1'b0;
   logic cal_done_i = 1'b0;
   logic [7:0] fuse_gain_i = 8'h00;
   logic [3:0] fuse_ref_i = 4'h0;
   logic [7:0] fuse_term_a_i = 8'h00;
   logic [7:0] fuse_term_b_i = 8'h00;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, core_sleep_o, core_settle_o, cal_start_o, lp_active_o;
   logic [7:0] core_gain_adjust_o, termination_adjust_a_o, termination_adjust_b_o;
   logic [3:0] reference_adjust_o;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int mdl [int];

   lpc_top #(.AW(12), .SLEEP_CNT(SLP), .SETTLE_CNT(STL)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .cal_trigger_pin_i(cal_trigger_pin_i),
      .cal_done_i(cal_done_i), .fuse_gain_i(fuse_gain_i), .fuse_ref_i(fuse_ref_i),
      .fuse_term_a_i(fuse_term_a_i), .fuse_term_b_i(fuse_term_b_i), .core_sleep_o(core_sleep_o),
      .core_settle_o(core_settle_o), .cal_start_o(cal_start_o), .lp_active_o(lp_active_o),
      .core_gain_adjust_o(core_gain_adjust_o), .reference_adjust_o(reference_adjust_o),
      .termination_adjust_a_o(termination_adjust_a_o), .termination_adjust_b_o(termination_adjust_b_o));

   always #2.5 clk_i = ~clk_i;

   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // hang guard, well above the longest test
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         stop_test();
      end
   end

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   function automatic int mask(input logic [7:0] idx);
      if (idx == lpc_pkg::IDX_REF)
         return 32'hF;
      if (idx == lpc_pkg::IDX_BG_EN || idx == lpc_pkg::IDX_TRIG_CFG || idx == lpc_pkg::IDX_SOFT_TRIG)
         return 32'h1;
      return 32'hFF;
   endfunction : mask

   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
            output logic err);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= {2'b00, idx, 2'b00};
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      logic err;
      apb(1'b1, idx, wd, rd, err);
      if (mdl.exists(idx))
         mdl[idx] = wd & mask(idx);
   endtask : wr

   task rd_chk(input logic [7:0] idx, input string nm);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 32'h0, rd, err);
      check(nm, rd, mdl.exists(idx) ? mdl[idx] : 32'h0);
      check("pslverr", err, !mdl.exists(idx));
   endtask : rd_chk

   task do_reset;
      rst_i <= 1'b1;
      fuse_gain_i <= 8'($urandom);
      fuse_ref_i <= 4'($urandom);
      fuse_term_a_i <= 8'($urandom);
      fuse_term_b_i <= 8'($urandom);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      mdl.delete();
      mdl[lpc_pkg::IDX_GAIN] = fuse_gain_i;
      mdl[lpc_pkg::IDX_REF] = fuse_ref_i;
      mdl[lpc_pkg::IDX_TERM_A] = fuse_term_a_i;
      mdl[lpc_pkg::IDX_TERM_B] = fuse_term_b_i;
      mdl[lpc_pkg::IDX_LP_CTL] = lpc_pkg::LP_CTL_RST;
      mdl[lpc_pkg::IDX_BG_EN] = 0;
      mdl[lpc_pkg::IDX_TRIG_CFG] = 0;
      mdl[lpc_pkg::IDX_SOFT_TRIG] = 1;
   endtask : do_reset

   task trim_ports;
      check("gain port", core_gain_adjust_o, mdl[lpc_pkg::IDX_GAIN]);
      check("ref port", reference_adjust_o, mdl[lpc_pkg::IDX_REF]);
      check("term a port", termination_adjust_a_o, mdl[lpc_pkg::IDX_TERM_A]);
      check("term b port", termination_adjust_b_o, mdl[lpc_pkg::IDX_TERM_B]);
   endtask : trim_ports

   // one sleep, settle and calibration pass; paced passes skip the sleep length
   task run_cycle(input int slp_exp, input int stl_exp, input bit paced, input int frz);
      int n;
      n = 0;
      while (core_sleep_o !== 1'b1)
         @(posedge clk_i);
      // low clock enable freezes the sleep, stretching it by frz cycles
      if (frz > 0)
      begin
         ce_i <= 1'b0;
         repeat (frz) @(posedge clk_i);
         ce_i <= 1'b1;
         n = frz;
      end
      while (core_sleep_o === 1'b1)
      begin
         @(posedge clk_i);
         n++;
      end
      if (!paced)
         check("sleep length", n, slp_exp + frz);
      n = 0;
      while (core_settle_o === 1'b1)
      begin
         @(posedge clk_i);
         n++;
      end
      check("settle length", n, stl_exp);
      check("cal start", cal_start_o, 1'b1);
      cal_done_i <= 1'b1;
      @(posedge clk_i);
      cal_done_i <= 1'b0;
      @(posedge clk_i);
      check("sleep after cal", core_sleep_o, 1'b1);
   endtask : run_cycle

   task paced_test(input bit sel);
      wr(lpc_pkg::IDX_TRIG_CFG, sel);
      wr(lpc_pkg::IDX_SOFT_TRIG, !sel);
      // the unselected source is held low, which would wake the core if used
      cal_trigger_pin_i <= sel;
      wr(lpc_pkg::IDX_LP_CTL, 32'h0B);
      while (core_sleep_o !== 1'b1)
         @(posedge clk_i);
      repeat (60) @(posedge clk_i);
      check("paced hold", core_sleep_o, 1'b1);
      if (sel)
         cal_trigger_pin_i <= 1'b0;
      else
         wr(lpc_pkg::IDX_SOFT_TRIG, 0);
      run_cycle(0, 13, 1'b1, 0);
      wr(lpc_pkg::IDX_LP_CTL, 0);
      repeat (2) @(posedge clk_i);
      check("idle after off", core_sleep_o, 1'b0);
      $display("test paced source %0d done", sel);
   endtask : paced_test

   initial
   begin
      int dummy;
      dummy = $urandom(32'h6C811331);
      do_reset();
      foreach (mdl[k])
         rd_chk(k, "reset value");
      trim_ports();
      rd_chk(8'h00, "unmapped read");
      $display("test reset values done");
      for (int k = 0; k < 4; k++)
      begin
         wr(lpc_pkg::IDX_GAIN + ((k == 0) ? 0 : 2 * k + (k == 3 ? -1 : 0)), $urandom);
      end
      wr(8'h01, 32'hFFFF_FFFF);
      rd_chk(lpc_pkg::IDX_GAIN, "gain");
      rd_chk(lpc_pkg::IDX_REF, "ref");
      rd_chk(lpc_pkg::IDX_TERM_A, "term a");
      rd_chk(lpc_pkg::IDX_TERM_B, "term b");
      trim_ports();
      $display("test trim writes done");
      // low-power enable alone must not start the scheduler
      wr(lpc_pkg::IDX_LP_CTL, 32'h89);
      repeat (20) @(posedge clk_i);
      check("active without bg", lp_active_o, 1'b0);
      check("sleep without bg", core_sleep_o, 1'b0);
      wr(lpc_pkg::IDX_BG_EN, 1);
      repeat (2) @(posedge clk_i);
      check("active with bg", lp_active_o, 1'b1);
      wr(lpc_pkg::IDX_LP_CTL, 0);
      $display("test enable gating done");
      for (int i = 0; i < 8; i++)
      begin
         wr(lpc_pkg::IDX_LP_CTL, (i << 5) | ((i % 4) << 3) | 1);
         run_cycle(8 + 3 * i, 10 + 3 * (i % 4), 1'b0, (i == 5) ? 6 : 0);
         wr(lpc_pkg::IDX_LP_CTL, 0);
      end
      rd_chk(lpc_pkg::IDX_LP_CTL, "ctl readback");
      $display("test autonomous codes done");
      wr(lpc_pkg::IDX_BG_EN, 1);
      paced_test(1'b1);
      paced_test(1'b0);
      do_reset();
      rd_chk(lpc_pkg::IDX_TERM_A, "term a reload");
      trim_ports();
      $display("test second reset done");
      stop_test();
   end
endmodule : tb_lowpower_bg_cal_and_trims
